// File: dma_pkg.sv
// constants, field layouts and types for the two channel fabric dma
// assumes a 64-bit axi data path and 4 kbyte transfers
package dma_pkg;

	localparam int BEAT_BYTES = 8;
	localparam int BURST_BEATS = 16;
	localparam int XFER_BYTES = 4096;
	localparam int BURST_BYTES = BEAT_BYTES * BURST_BEATS;
	localparam int XFER_BURSTS = XFER_BYTES / BURST_BYTES;
	localparam int XFER_BEATS = XFER_BYTES / BEAT_BYTES;
	localparam int DATA_W = BEAT_BYTES * 8;
	localparam int RAM_AW = 9;
	localparam int PADDR_W = 6;

	localparam logic [7:0] AXI_LEN = 8'h0F;
	localparam logic [2:0] AXI_SIZE = 3'h3;
	localparam logic [1:0] AXI_INCR = 2'h1;

	// register offsets inside one channel block, channel picked by paddr[5]
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_STATUS = 5'h04;
	localparam logic [4:0] OFF_SRC = 5'h08;
	localparam logic [4:0] OFF_DST = 5'h0C;
	localparam logic [4:0] OFF_CYCLES = 5'h10;
	localparam int CHAN_SEL_BIT = 5;

	localparam int CTRL_START_BIT = 8;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR = 2;
	localparam int ST_EMPTY = 3;

	localparam logic [31:0] RESET_WORD = 32'h00000000;

	// fill: source into buffer; stage: source through buffer; drain: buffer out
	typedef enum logic [1:0] {
		MODE_FILL,
		MODE_STAGE,
		MODE_DRAIN,
		MODE_BAD
	} mode_type;

	// one channel: setup, status, timer, burst counters and port registers
	typedef struct packed {
		mode_type mode;
		logic [31:0] src;
		logic [31:0] dst;
		logic busy;
		logic done;
		logic err;
		logic [31:0] cycles;
		logic [5:0] ar_cnt;
		logic [9:0] rv_cnt;
		logic [5:0] aw_cnt;
		logic [9:0] wb_cnt;
		logic [5:0] b_cnt;
		logic pend;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic wlast;
		logic bready;
	} chan_type;

	typedef struct packed {
		chan_type [1:0] ch;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_type;

endpackage

// File: fabric_buffer_ram.sv
// dual port block ram staging one channel's transfer
// one write port, one registered read port, same clock
`timescale 1ns/1ns
module fabric_buffer_ram #(
	parameter int AW = 9,
	parameter int DW = 64
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (re) begin
			rdata <= mem[raddr];
		end
	end

endmodule

// File: two_channel_fabric_dma.sv
// two channel fabric dma: apb setup, host and ddr axi masters, buffer rams
// assumes axi slaves on the host bridge and on the ddr controller
`timescale 1ns/1ns
module two_channel_fabric_dma (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [dma_pkg::PADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic host_arvalid,
	input wire logic host_arready,
	output logic [31:0] host_araddr,
	output logic [7:0] host_arlen,
	output logic [2:0] host_arsize,
	output logic [1:0] host_arburst,
	input wire logic host_rvalid,
	output logic host_rready,
	input wire logic [dma_pkg::DATA_W-1:0] host_rdata,
	input wire logic [1:0] host_rresp,
	input wire logic host_rlast,
	output logic host_awvalid,
	input wire logic host_awready,
	output logic [31:0] host_awaddr,
	output logic [7:0] host_awlen,
	output logic [2:0] host_awsize,
	output logic [1:0] host_awburst,
	output logic host_wvalid,
	input wire logic host_wready,
	output logic [dma_pkg::DATA_W-1:0] host_wdata,
	output logic [dma_pkg::BEAT_BYTES-1:0] host_wstrb,
	output logic host_wlast,
	input wire logic host_bvalid,
	output logic host_bready,
	input wire logic [1:0] host_bresp,
	output logic ddr_arvalid,
	input wire logic ddr_arready,
	output logic [31:0] ddr_araddr,
	output logic [7:0] ddr_arlen,
	output logic [2:0] ddr_arsize,
	output logic [1:0] ddr_arburst,
	input wire logic ddr_rvalid,
	output logic ddr_rready,
	input wire logic [dma_pkg::DATA_W-1:0] ddr_rdata,
	input wire logic [1:0] ddr_rresp,
	input wire logic ddr_rlast,
	output logic ddr_awvalid,
	input wire logic ddr_awready,
	output logic [31:0] ddr_awaddr,
	output logic [7:0] ddr_awlen,
	output logic [2:0] ddr_awsize,
	output logic [1:0] ddr_awburst,
	output logic ddr_wvalid,
	input wire logic ddr_wready,
	output logic [dma_pkg::DATA_W-1:0] ddr_wdata,
	output logic [dma_pkg::BEAT_BYTES-1:0] ddr_wstrb,
	output logic ddr_wlast,
	input wire logic ddr_bvalid,
	output logic ddr_bready,
	input wire logic [1:0] ddr_bresp
);

	dma_pkg::state_type state_reg, state_next;
	// port side arrays: index = channel
	logic [1:0] arready_in, rvalid_in, awready_in, wready_in, bvalid_in, ram_we, ram_re;
	logic [1:0][dma_pkg::DATA_W-1:0] rdata_in, ram_q;
	logic [1:0][1:0] rresp_in, bresp_in;
	logic [1:0][dma_pkg::RAM_AW-1:0] ram_wa, ram_ra;

	function automatic logic reads_source(input dma_pkg::mode_type m);
		return (m == dma_pkg::MODE_FILL) || (m == dma_pkg::MODE_STAGE);
	endfunction

	function automatic logic writes_dest(input dma_pkg::mode_type m);
		return (m == dma_pkg::MODE_STAGE) || (m == dma_pkg::MODE_DRAIN);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// channel 0 reads host, writes ddr
	assign arready_in = {ddr_arready, host_arready};
	assign rvalid_in = {ddr_rvalid, host_rvalid};
	assign rdata_in = {ddr_rdata, host_rdata};
	assign rresp_in = {ddr_rresp, host_rresp};
	assign awready_in = {host_awready, ddr_awready};
	assign wready_in = {host_wready, ddr_wready};
	assign bvalid_in = {host_bvalid, ddr_bvalid};
	assign bresp_in = {host_bresp, ddr_bresp};

	for (genvar g = 0; g < 2; g++) begin : g_ram
		fabric_buffer_ram #(
			.AW(dma_pkg::RAM_AW),
			.DW(dma_pkg::DATA_W)
		) u_ram (
			.clk(pclk),
			.we(ram_we[g]),
			.waddr(ram_wa[g]),
			.wdata(rdata_in[g]),
			.re(ram_re[g]),
			.raddr(ram_ra[g]),
			.rdata(ram_q[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [4:0] off;
		logic csel;
		logic mapped;
		off = paddr[4:0];
		csel = paddr[dma_pkg::CHAN_SEL_BIT];
		mapped = 1'b0;
		state_next = state_reg;
		ram_we = '0;
		ram_wa = '0;
		ram_re = '0;
		ram_ra = '0;
		for (int c = 0; c < 2; c++) begin
			// fixed-size bursts on the read port
			if (state_reg.ch[c].arvalid && arready_in[c]) begin
				state_next.ch[c].arvalid = 1'b0;
				state_next.ch[c].ar_cnt = state_reg.ch[c].ar_cnt + 6'h01;
				state_next.ch[c].araddr = state_reg.ch[c].araddr
					+ 32'(dma_pkg::BURST_BYTES);
			end else if (state_reg.ch[c].busy && reads_source(state_reg.ch[c].mode)
					&& !state_reg.ch[c].arvalid
					&& state_reg.ch[c].ar_cnt < 6'(dma_pkg::XFER_BURSTS)) begin
				state_next.ch[c].arvalid = 1'b1;
			end
			if (rvalid_in[c] && state_reg.ch[c].rready) begin
				ram_we[c] = 1'b1;
				ram_wa[c] = state_reg.ch[c].rv_cnt[dma_pkg::RAM_AW-1:0];
				state_next.ch[c].rv_cnt = state_reg.ch[c].rv_cnt + 10'h001;
				if (rresp_in[c] != 2'h0) begin
					state_next.ch[c].err = 1'b1;
				end
			end
			// write side runs on its own counters
			if (state_reg.ch[c].awvalid && awready_in[c]) begin
				state_next.ch[c].awvalid = 1'b0;
				state_next.ch[c].aw_cnt = state_reg.ch[c].aw_cnt + 6'h01;
				state_next.ch[c].awaddr = state_reg.ch[c].awaddr
					+ 32'(dma_pkg::BURST_BYTES);
			end else if (state_reg.ch[c].busy && writes_dest(state_reg.ch[c].mode)
					&& !state_reg.ch[c].awvalid
					&& state_reg.ch[c].aw_cnt < 6'(dma_pkg::XFER_BURSTS)) begin
				state_next.ch[c].awvalid = 1'b1;
			end
			if (state_reg.ch[c].wvalid && wready_in[c]) begin
				state_next.ch[c].wvalid = 1'b0;
			end
			if (state_reg.ch[c].pend) begin
				state_next.ch[c].pend = 1'b0;
				state_next.ch[c].wvalid = 1'b1;
				state_next.ch[c].wdata = ram_q[c];
				state_next.ch[c].wlast = state_reg.ch[c].wb_cnt[3:0] == 4'h0;
			end
			// read a word only once it has been stored
			if (state_reg.ch[c].busy && writes_dest(state_reg.ch[c].mode)
					&& !state_next.ch[c].wvalid && !state_reg.ch[c].pend
					&& state_reg.ch[c].wb_cnt < 10'(dma_pkg::XFER_BEATS)
					&& state_reg.ch[c].wb_cnt < state_reg.ch[c].rv_cnt) begin
				ram_re[c] = 1'b1;
				ram_ra[c] = state_reg.ch[c].wb_cnt[dma_pkg::RAM_AW-1:0];
				state_next.ch[c].pend = 1'b1;
				state_next.ch[c].wb_cnt = state_reg.ch[c].wb_cnt + 10'h001;
			end
			if (bvalid_in[c] && state_reg.ch[c].bready) begin
				state_next.ch[c].b_cnt = state_reg.ch[c].b_cnt + 6'h01;
				if (bresp_in[c] != 2'h0) begin
					state_next.ch[c].err = 1'b1;
				end
			end
			// timer runs until completion is seen
			if (state_reg.ch[c].busy) begin
				state_next.ch[c].cycles = state_reg.ch[c].cycles + 32'h00000001;
			end
			// completion when each side the mode uses has finished
			if (state_reg.ch[c].busy
					&& (!reads_source(state_reg.ch[c].mode)
						|| state_reg.ch[c].rv_cnt == 10'(dma_pkg::XFER_BEATS))
					&& (!writes_dest(state_reg.ch[c].mode)
						|| state_reg.ch[c].b_cnt == 6'(dma_pkg::XFER_BURSTS))) begin
				state_next.ch[c].busy = 1'b0;
				state_next.ch[c].done = 1'b1;
			end
		end

		// apb: no wait state, answer prepared in the setup cycle
		state_next.pready = 1'b0;
		state_next.pslverr = 1'b0;
		if (psel && !penable) begin
			mapped = paddr[1:0] == 2'h0 && off <= dma_pkg::OFF_CYCLES;
			state_next.pready = 1'b1;
			state_next.pslverr = !mapped;
			unique case (off)
				dma_pkg::OFF_CTRL: state_next.prdata = {30'h00000000,
					state_reg.ch[csel].mode};
				dma_pkg::OFF_STATUS: state_next.prdata = {28'h0000000,
					state_reg.ch[csel].rv_cnt == state_reg.ch[csel].wb_cnt,
					state_reg.ch[csel].err, state_reg.ch[csel].done,
					state_reg.ch[csel].busy};
				dma_pkg::OFF_SRC: state_next.prdata = state_reg.ch[csel].src;
				dma_pkg::OFF_DST: state_next.prdata = state_reg.ch[csel].dst;
				dma_pkg::OFF_CYCLES: state_next.prdata = state_reg.ch[csel].cycles;
				default: state_next.prdata = dma_pkg::RESET_WORD;
			endcase
			if (!mapped) begin
				state_next.prdata = dma_pkg::RESET_WORD;
			end
		end
		if (psel && penable && state_reg.pready && pwrite && !state_reg.pslverr) begin
			// addresses written before start; mode taken only with the start bit
			unique case (off)
				dma_pkg::OFF_SRC: state_next.ch[csel].src = pwdata;
				dma_pkg::OFF_DST: state_next.ch[csel].dst = pwdata;
				dma_pkg::OFF_CTRL: begin
					// status and count hold until a new start
					if (pwdata[dma_pkg::CTRL_START_BIT] && !state_reg.ch[csel].busy) begin
						// mode selects which engines take part
						state_next.ch[csel].mode = dma_pkg::mode_type'(pwdata[1:0]);
						// timer cleared and started with the transfer
						state_next.ch[csel].cycles = 32'h00000000;
						state_next.ch[csel].done = 1'b0;
						state_next.ch[csel].err = 1'b0;
						state_next.ch[csel].busy = 1'b1;
						state_next.ch[csel].ar_cnt = 6'h00;
						state_next.ch[csel].aw_cnt = 6'h00;
						state_next.ch[csel].b_cnt = 6'h00;
						state_next.ch[csel].wb_cnt = 10'h000;
						state_next.ch[csel].rv_cnt = 10'h000;
						state_next.ch[csel].araddr = state_reg.ch[csel].src;
						state_next.ch[csel].awaddr = state_reg.ch[csel].dst;
						// drain sends a buffer already full
						if (pwdata[1:0] == 2'(dma_pkg::MODE_DRAIN)) begin
							state_next.ch[csel].rv_cnt = 10'(dma_pkg::XFER_BEATS);
						end
						if (pwdata[1:0] == 2'(dma_pkg::MODE_BAD)) begin
							state_next.ch[csel].busy = 1'b0;
							state_next.ch[csel].done = 1'b1;
							state_next.ch[csel].err = 1'b1;
						end
					end
				end
				default: ;
			endcase
		end
		for (int c = 0; c < 2; c++) begin
			state_next.ch[c].rready = state_next.ch[c].busy
				&& reads_source(state_next.ch[c].mode)
				&& state_next.ch[c].rv_cnt < 10'(dma_pkg::XFER_BEATS);
			state_next.ch[c].bready = state_next.ch[c].busy
				&& writes_dest(state_next.ch[c].mode)
				&& state_next.ch[c].b_cnt < 6'(dma_pkg::XFER_BURSTS);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;

	assign host_arvalid = state_reg.ch[0].arvalid;
	assign host_araddr = state_reg.ch[0].araddr;
	assign host_rready = state_reg.ch[0].rready;
	assign ddr_awvalid = state_reg.ch[0].awvalid;
	assign ddr_awaddr = state_reg.ch[0].awaddr;
	assign ddr_wvalid = state_reg.ch[0].wvalid;
	assign ddr_wdata = state_reg.ch[0].wdata;
	assign ddr_wlast = state_reg.ch[0].wlast;
	assign ddr_bready = state_reg.ch[0].bready;

	assign ddr_arvalid = state_reg.ch[1].arvalid;
	assign ddr_araddr = state_reg.ch[1].araddr;
	assign ddr_rready = state_reg.ch[1].rready;
	assign host_awvalid = state_reg.ch[1].awvalid;
	assign host_awaddr = state_reg.ch[1].awaddr;
	assign host_wvalid = state_reg.ch[1].wvalid;
	assign host_wdata = state_reg.ch[1].wdata;
	assign host_wlast = state_reg.ch[1].wlast;
	assign host_bready = state_reg.ch[1].bready;

	// fixed burst shape on every address channel
	assign host_arlen = dma_pkg::AXI_LEN;
	assign host_awlen = dma_pkg::AXI_LEN;
	assign ddr_arlen = dma_pkg::AXI_LEN;
	assign ddr_awlen = dma_pkg::AXI_LEN;
	assign host_arsize = dma_pkg::AXI_SIZE;
	assign host_awsize = dma_pkg::AXI_SIZE;
	assign ddr_arsize = dma_pkg::AXI_SIZE;
	assign ddr_awsize = dma_pkg::AXI_SIZE;
	assign host_arburst = dma_pkg::AXI_INCR;
	assign host_awburst = dma_pkg::AXI_INCR;
	assign ddr_arburst = dma_pkg::AXI_INCR;
	assign ddr_awburst = dma_pkg::AXI_INCR;
	assign host_wstrb = '1;
	assign ddr_wstrb = '1;

endmodule

// File: dma_monitor.sv
// assertion checker for the two channel dma ports
// bound to the dma top, sees only its ports
`timescale 1ns/1ns
module dma_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic host_arvalid,
	input wire logic host_arready,
	input wire logic [31:0] host_araddr,
	input wire logic [7:0] host_arlen,
	input wire logic ddr_arvalid,
	input wire logic [7:0] ddr_arlen,
	input wire logic host_awvalid,
	input wire logic [7:0] host_awlen,
	input wire logic ddr_wvalid,
	input wire logic ddr_wready,
	input wire logic [63:0] ddr_wdata,
	input wire logic ddr_wlast
);
	logic [3:0] beat_reg;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////
	// beat position inside a ddr write burst
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			beat_reg <= 4'h0;
		else if (ddr_wvalid && ddr_wready)
			beat_reg <= beat_reg + 4'h1;
	end
	a_pready_one: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_setup_answer: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_error_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_host_rd_len: assert property (host_arvalid |-> host_arlen == 8'h0F)
		else $error("host read burst length");
	a_ddr_rd_len: assert property (ddr_arvalid |-> ddr_arlen == 8'h0F)
		else $error("ddr read burst length");
	a_host_wr_len: assert property (host_awvalid |-> host_awlen == 8'h0F)
		else $error("host write burst length");
	a_ar_hold: assert property (host_arvalid && !host_arready |=>
		host_arvalid && $stable(host_araddr))
		else $error("read address dropped");
	a_w_hold: assert property (ddr_wvalid && !ddr_wready |=>
		ddr_wvalid && $stable(ddr_wdata))
		else $error("write beat dropped");
	a_wlast_beat: assert property (ddr_wvalid |-> ddr_wlast == (beat_reg == 4'hF))
		else $error("wlast off the sixteenth beat");
	a_ar_gap: assert property (host_arvalid && host_arready |=> !host_arvalid)
		else $error("no gap between read bursts");
	c_read_burst: cover property (host_arvalid && host_arready);
	c_write_last: cover property (ddr_wvalid && ddr_wready && ddr_wlast);
	c_bad_addr: cover property (pslverr);
endmodule

bind two_channel_fabric_dma dma_monitor mon_u (.*);

// File: axi_slave_model.sv
// axi slave standing for the host bridge or the ddr controller
// logs addresses and write beats for the bench to inspect
`timescale 1ns/1ns
module axi_slave_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic stall,
	input wire logic fault,
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [63:0] rdata,
	output logic [1:0] rresp,
	output logic rlast,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [63:0] wdata,
	input wire logic wlast,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp
);
	int arlog[$];
	int awlog[$];
	int rq[$];
	logic [63:0] wlog[$];
	int rb;
	int bn;
	time t_rl;
	time t_w0;
	function automatic logic [63:0] pat(input int a);
		return {a, ~a};
	endfunction
	////////////////////////////////////////////////
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			arready <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			rvalid <= 1'b0;
			rlast <= 1'b0;
			rresp <= 2'h0;
			rdata <= 64'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			rq.delete();
			rb = 0;
			bn = 0;
		end else begin
			arready <= !stall || $urandom_range(1);
			awready <= !stall || $urandom_range(1);
			wready <= !stall || $urandom_range(1);
			if (arvalid && arready) begin
				arlog.push_back(araddr);
				rq.push_back(araddr);
			end
			if (awvalid && awready)
				awlog.push_back(awaddr);
			if (wvalid && wready) begin
				wlog.push_back(wdata);
				if (wlog.size() == 1)
					t_w0 = $time;
				if (wlast)
					bn++;
			end
			if (rvalid && rready) begin
				if (rlast) begin
					t_rl = $time;
					void'(rq.pop_front());
				end
				rb = rlast ? 0 : rb + 1;
			end
			if ((!rvalid || rready) && rq.size() > 0 && (!stall || $urandom_range(1))) begin
				rvalid <= 1'b1;
				rdata <= pat(rq[0] + 8 * rb);
				rlast <= rb == 15;
				rresp <= fault ? 2'h2 : 2'h0;
			end else if (!rvalid || rready) begin
				rvalid <= 1'b0;
				rdata <= ~rdata;
			end
			if ((!bvalid || bready) && bn > 0 && (!stall || $urandom_range(1))) begin
				bvalid <= 1'b1;
				bresp <= fault ? 2'h2 : 2'h0;
				bn--;
			end else if (bready)
				bvalid <= 1'b0;
		end
	end
endmodule

// File: testbench.sv
// self-checking bench for the two channel dma
// apb master here, axi slave models on both far ports
`timescale 1ns/1ns
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, fault, e;
	logic [5:0] paddr;
	logic [31:0] pwdata, prdata, q, host_araddr, host_awaddr, ddr_araddr, ddr_awaddr;
	logic [7:0] host_arlen, host_awlen, ddr_arlen, ddr_awlen, host_wstrb, ddr_wstrb;
	logic [2:0] host_arsize, host_awsize, ddr_arsize, ddr_awsize;
	logic [1:0] host_arburst, host_awburst, ddr_arburst, ddr_awburst;
	logic [1:0] host_rresp, host_bresp, ddr_rresp, ddr_bresp;
	logic [63:0] host_rdata, host_wdata, ddr_rdata, ddr_wdata;
	logic host_arvalid, host_arready, host_rvalid, host_rready, host_rlast, host_awvalid;
	logic host_awready, host_wvalid, host_wready, host_wlast, host_bvalid, host_bready;
	logic ddr_arvalid, ddr_arready, ddr_rvalid, ddr_rready, ddr_rlast, ddr_awvalid;
	logic ddr_awready, ddr_wvalid, ddr_wready, ddr_wlast, ddr_bvalid, ddr_bready;
	int err_total, cmp_count, cyc;
	int base[2];
	int chs[8] = '{0, 0, 0, 1, 1, 1, 0, 1};
	int ms[8] = '{0, 2, 1, 0, 2, 1, 3, 1};
	two_channel_fabric_dma dut_u (.*);
	axi_slave_model p_host (.clk(pclk), .rstn(presetn), .stall(stall), .fault(fault),
		.arvalid(host_arvalid), .arready(host_arready), .araddr(host_araddr),
		.rvalid(host_rvalid), .rready(host_rready), .rdata(host_rdata), .rresp(host_rresp),
		.rlast(host_rlast), .awvalid(host_awvalid), .awready(host_awready),
		.awaddr(host_awaddr), .wvalid(host_wvalid), .wready(host_wready),
		.wdata(host_wdata), .wlast(host_wlast), .bvalid(host_bvalid),
		.bready(host_bready), .bresp(host_bresp));
	axi_slave_model p_ddr (.clk(pclk), .rstn(presetn), .stall(stall), .fault(fault),
		.arvalid(ddr_arvalid), .arready(ddr_arready), .araddr(ddr_araddr),
		.rvalid(ddr_rvalid), .rready(ddr_rready), .rdata(ddr_rdata), .rresp(ddr_rresp),
		.rlast(ddr_rlast), .awvalid(ddr_awvalid), .awready(ddr_awready),
		.awaddr(ddr_awaddr), .wvalid(ddr_wvalid), .wready(ddr_wready),
		.wdata(ddr_wdata), .wlast(ddr_wlast), .bvalid(ddr_bvalid),
		.bready(ddr_bready), .bresp(ddr_bresp));
	always #5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	////////////////////////////////////////////////
	task automatic close_out;
		$display("mismatches %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tmo;
		err_total++;
		$display("[ERR] %0t wait ran out", $time);
		close_out;
	endtask
	task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			tmo;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input int ch, input int mode, input int src, input int dst,
		input logic err_exp);
		logic [5:0] b;
		logic [63:0] x;
		int t0, cy, k;
		int arl[$], awl[$];
		logic [63:0] wl[$];
		b = ch ? 6'h20 : 6'h00;
		p_host.arlog.delete();
		p_host.awlog.delete();
		p_host.wlog.delete();
		p_ddr.arlog.delete();
		p_ddr.awlog.delete();
		p_ddr.wlog.delete();
		apb(1'b1, b + 6'h08, src);
		apb(1'b1, b + 6'h0C, dst);
		apb(1'b1, b, mode | 32'h100);
		t0 = cyc;
		k = 0;
		do begin
			apb(1'b0, b + 6'h04, 32'h0);
			k++;
		end while (q[1] !== 1'b1 && k < 3000);
		if (q[1] !== 1'b1)
			tmo;
		check(q & 32'h7, {29'h0, err_exp, 2'h2});
		apb(1'b0, b + 6'h10, 32'h0);
		cy = q;
		check(32'(q >= (mode == 3 ? 0 : 512) && q <= cyc - t0), 32'h1);
		check(32'(mode == 3 || 409600 / cy <= (mode == 0 ? 800 : 400)), 32'h1);
		apb(1'b0, b + 6'h10, 32'h0);
		check(q, cy);
		apb(1'b0, b + 6'h04, 32'h0);
		check(q & 32'h7, {29'h0, err_exp, 2'h2});
		arl = ch ? p_ddr.arlog : p_host.arlog;
		awl = ch ? p_host.awlog : p_ddr.awlog;
		wl = ch ? p_host.wlog : p_ddr.wlog;
		check(arl.size(), mode < 2 ? 32 : 0);
		check(awl.size(), (mode == 1 || mode == 2) ? 32 : 0);
		check(wl.size(), (mode == 1 || mode == 2) ? 512 : 0);
		for (int i = 0; i < arl.size(); i++)
			check(arl[i], src + 128 * i);
		for (int i = 0; i < awl.size(); i++)
			check(awl[i], dst + 128 * i);
		for (int i = 0; i < wl.size(); i++) begin
			x = p_host.pat((mode == 2 ? base[ch] : src) + 8 * i);
			check(wl[i][63:32], x[63:32]);
			check(wl[i][31:0], x[31:0]);
		end
		if (mode == 1)
			check(32'(ch ? p_host.t_w0 < p_ddr.t_rl : p_ddr.t_w0 < p_host.t_rl), 32'h1);
		if (mode < 2)
			base[ch] = src;
	endtask
	////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 6'h00;
		pwdata = 32'h0;
		stall = 1'b0;
		fault = 1'b0;
		err_total = 0;
		cmp_count = 0;
		cyc = 0;
		void'($urandom(32'hDA93));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 6'h04, 32'h0);
		check(q, 32'h8);
		check({host_arsize, host_awsize, ddr_arsize, ddr_awsize}, 32'h000006DB);
		check({host_arburst, host_awburst, ddr_arburst, ddr_awburst}, 32'h00000055);
		check({host_wstrb, ddr_wstrb}, 32'h0000FFFF);
		apb(1'b0, 6'h34, 32'h0);
		check(q, 32'h0);
		check({31'h0, e}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk);
			stall <= i % 2;
			fault <= i == 7;
			run(chs[i], ms[i], $urandom & 32'h7FFFF000, $urandom & 32'h7FFFF000, i >= 6);
		end
		close_out;
	end
endmodule
